// >>> mil_consts.svh
// offsets, field positions, reset values and counts of the interrupt logic
`ifndef MIL_CONSTS_SVH
`define MIL_CONSTS_SVH

// register byte offsets on the register bus
`define MIL_OFF_IRQ_CONTROL 8'h00
`define MIL_OFF_OPTION      8'h04
`define MIL_OFF_PFLAGS_ONE  8'h08
`define MIL_OFF_PENABLE_ONE 8'h0c
`define MIL_OFF_STATUS      8'h10

// irq_control field positions
`define MIL_IC_GLOBAL_EN  7
`define MIL_IC_PERIPH_EN  6
`define MIL_IC_TMR_EN     5
`define MIL_IC_EXT_EN     4
`define MIL_IC_PORT_EN    3
`define MIL_IC_TMR_FLAG   2
`define MIL_IC_EXT_FLAG   1
`define MIL_IC_PORT_FLAG  0

// option field position and reset value
`define MIL_OPT_EDGE_SEL  6
`define MIL_OPTION_RESET  1'b1
`define MIL_IRQ_CONTROL_RESET 8'h00

// peripheral flag/enable position of the converter-done request
`define MIL_PF_CONV_DONE  0

// core timing
`define MIL_IRQ_VECTOR    13'h0004
`define MIL_PHASE_LAST    2'h3
`define MIL_PHASE_ONE     2'h0
`define MIL_PHASE_TWO     2'h1
`define MIL_DUMMY_CYCLES  2'h2

// pin-change race of one variant: 1 reproduces the missed flag
`define MIL_PORT_READ_RACE 1'b0

`endif

// >>> mil_core_model.sv
// behavioural model of the core sequencer facing the interrupt logic
`timescale 1ns/1ns
`default_nettype none
`include "mil_consts.svh"
module mil_core_model
  import mil_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire mil_order_t i_order,
  input  wire logic       i_do_return,
  input  wire logic       i_do_sleep,
  output var  mil_core_t  o_core,
  output logic      [3:0] o_depth
);
  // ----------------------------------------
  // instruction events
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core <= '0;
    else
    begin
      o_core.return_from_irq_instr <= i_do_return;
      o_core.sleep_enter <= i_do_sleep;
      o_core.port_read <= 1'b0;
      // pc runs on, jumping to the vector when ordered
      o_core.ret_addr <= i_order.load_pc ? `MIL_IRQ_VECTOR : o_core.ret_addr + 13'h1;
    end
  end

  // ----------------------------------------
  // hardware stack depth
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_depth <= 4'h0;
    else if (i_order.push)
      o_depth <= o_depth + 4'h1;
    else if (i_order.pop)
      o_depth <= o_depth - 4'h1;
  end
endmodule
`default_nettype wire

// >>> mil_irq_logic.sv
// interrupt logic of the small controller core with an ahb-lite register slave
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "mil_consts.svh"

module mil_irq_logic
  import mil_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire mil_src_t    i_src,
  input  wire mil_core_t   i_core,
  output mil_order_t       o_order,
  output logic             o_dummy_cycle,
  output logic             o_sleeping,
  output logic             o_phase_one
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    unique case (a)
      `MIL_OFF_IRQ_CONTROL: reg_index = 3'h1;
      `MIL_OFF_OPTION:      reg_index = 3'h2;
      `MIL_OFF_PFLAGS_ONE:  reg_index = 3'h3;
      `MIL_OFF_PENABLE_ONE: reg_index = 3'h4;
      `MIL_OFF_STATUS:      reg_index = 3'h5;
      default:              reg_index = 3'h0;
    endcase
  endfunction

  logic [7:0] irq_control_q;
  logic [7:0] irq_control_d;
  logic       edge_sel_q;
  logic       pflag_q;
  logic       pflag_d;
  logic       penable_q;
  logic [1:0] phase_q;
  logic [1:0] dummy_cnt_q;
  logic       pin_prev_q;
  logic [3:0] port_prev_q;
  logic [2:0] wake_mask_q;
  logic       wr_pend_q;
  logic [2:0] wr_idx_q;
  logic [31:0] rdata_q;
  mil_state_t state_q;
  mil_order_t order_q;

  // zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  logic addr_ok;
  logic [2:0] acc_idx;
  assign addr_ok = hsel & htrans[1] & hready;
  assign acc_idx = reg_index(haddr[7:0]);

  // ----------------------------------------------------------------
  // instruction phase divider
  // ----------------------------------------------------------------
  logic q1_en;
  assign q1_en       = (phase_q == `MIL_PHASE_ONE);
  assign o_phase_one = q1_en;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;

  // ----------------------------------------------------------------
  // source event detection
  // ----------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;
  logic ext_evt;
  logic port_evt;
  assign pin_rise = i_src.ext_irq_pin & ~pin_prev_q;
  assign pin_fall = ~i_src.ext_irq_pin & pin_prev_q;
  assign ext_evt  = edge_sel_q ? pin_rise : pin_fall;
  assign port_evt = (i_src.port_hi != port_prev_q)
    & ~(`MIL_PORT_READ_RACE & i_core.port_read & (phase_q == `MIL_PHASE_TWO));

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      pin_prev_q  <= 1'b0;
      port_prev_q <= 4'h0;
    end
    else
    begin
      pin_prev_q  <= i_src.ext_irq_pin;
      port_prev_q <= i_src.port_hi;
    end

  // ----------------------------------------------------------------
  // request and wake logic
  // ----------------------------------------------------------------
  logic [2:0] pend_src;
  logic       periph_pend;
  logic       any_pend;
  logic       take;
  logic       wake_any;
  logic       sw_wr;
  assign sw_wr = wr_pend_q;
  // flags gated by their own enables; peripheral needs master enable too
  assign pend_src[0] = irq_control_q[`MIL_IC_PORT_FLAG] & irq_control_q[`MIL_IC_PORT_EN];
  assign pend_src[1] = irq_control_q[`MIL_IC_EXT_FLAG]  & irq_control_q[`MIL_IC_EXT_EN];
  assign pend_src[2] = irq_control_q[`MIL_IC_TMR_FLAG]  & irq_control_q[`MIL_IC_TMR_EN];
  assign periph_pend = pflag_q & penable_q & irq_control_q[`MIL_IC_PERIPH_EN];
  assign any_pend    = (|pend_src) | periph_pend;
  // sampled only at phase one, so latency lands at zero to three cycles
  assign take = (state_q == ST_RUN) & q1_en & any_pend
              & irq_control_q[`MIL_IC_GLOBAL_EN];
  // pin wake uses the enable captured at sleep entry
  assign wake_any = (irq_control_q[`MIL_IC_EXT_FLAG] & wake_mask_q[0])
                  | (irq_control_q[`MIL_IC_TMR_FLAG] & wake_mask_q[1])
                  | (irq_control_q[`MIL_IC_PORT_FLAG] & wake_mask_q[2])
                  | periph_pend;

  logic wake_vec;
  assign wake_vec = (state_q == ST_SLEEP) & wake_any
                  & irq_control_q[`MIL_IC_GLOBAL_EN];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      state_q     <= ST_RUN;
      dummy_cnt_q <= 2'h0;
      wake_mask_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
          if (take)
          begin
            state_q     <= ST_DUMMY;
            dummy_cnt_q <= `MIL_DUMMY_CYCLES;
          end
          else if (i_core.sleep_enter)
          begin
            state_q     <= ST_SLEEP;
            wake_mask_q <= {irq_control_q[`MIL_IC_PORT_EN],
                            irq_control_q[`MIL_IC_TMR_EN],
                            irq_control_q[`MIL_IC_EXT_EN]};
          end
        ST_DUMMY:
          // the vector is taken in phase one, so each dummy cycle closes at the next phase one
          if (phase_q == `MIL_PHASE_ONE)
          begin
            dummy_cnt_q <= dummy_cnt_q - 2'h1;
            if (dummy_cnt_q == 2'h1)
              state_q <= ST_RUN;
          end
        ST_SLEEP:
          if (wake_any & q1_en)
          begin
            if (wake_vec)
            begin
              state_q     <= ST_DUMMY;
              dummy_cnt_q <= `MIL_DUMMY_CYCLES;
            end
            else
              state_q <= ST_RUN;
          end
      endcase
    end

  assign o_dummy_cycle = (state_q == ST_DUMMY);
  assign o_sleeping    = (state_q == ST_SLEEP);

  logic vec_go;
  assign vec_go = take | (wake_vec & q1_en);

  // orders to the core, held one clock
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
      order_q <= '0;
    else
    begin
      order_q.load_pc  <= vec_go;
      order_q.push     <= vec_go;
      order_q.pc_value <= `MIL_IRQ_VECTOR;
      order_q.pop      <= i_core.return_from_irq_instr;
      order_q.wake     <= (state_q == ST_SLEEP) & wake_any & q1_en;
    end

  assign o_order = order_q;

  // ----------------------------------------------------------------
  // control and flag registers
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_control_d = irq_control_q;
    pflag_d       = pflag_q;
    if (sw_wr && wr_idx_q == 3'h1)
      irq_control_d = hwdata[7:0];
    if (sw_wr && wr_idx_q == 3'h3)
      pflag_d = hwdata[`MIL_PF_CONV_DONE];
    // events win over a clearing write; flags never auto-clear
    irq_control_d[`MIL_IC_EXT_FLAG]  = irq_control_d[`MIL_IC_EXT_FLAG] | ext_evt;
    irq_control_d[`MIL_IC_TMR_FLAG]  = irq_control_d[`MIL_IC_TMR_FLAG]
                                     | i_src.timer_wrap;
    irq_control_d[`MIL_IC_PORT_FLAG] = irq_control_d[`MIL_IC_PORT_FLAG] | port_evt;
    pflag_d = pflag_d | i_src.conv_done;
    if (i_core.return_from_irq_instr)
      irq_control_d[`MIL_IC_GLOBAL_EN] = 1'b1;
    if (vec_go)
      irq_control_d[`MIL_IC_GLOBAL_EN] = 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      irq_control_q <= `MIL_IRQ_CONTROL_RESET;
      pflag_q       <= 1'b0;
    end
    else
    begin
      irq_control_q <= irq_control_d;
      pflag_q       <= pflag_d;
    end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      edge_sel_q <= `MIL_OPTION_RESET;
      penable_q  <= 1'b0;
    end
    else if (sw_wr)
    begin
      if (wr_idx_q == 3'h2)
        edge_sel_q <= hwdata[`MIL_OPT_EDGE_SEL];
      if (wr_idx_q == 3'h4)
        penable_q <= hwdata[`MIL_PF_CONV_DONE];
    end

  // ----------------------------------------------------------------
  // bus slave: address phase capture and read data
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 3'h0;
      rdata_q   <= 32'h0;
    end
    else
    begin
      wr_pend_q <= addr_ok & hwrite;
      wr_idx_q  <= acc_idx;
      // flags are the only source identification software gets
      unique case (acc_idx)
        3'h1:    rdata_q <= {24'h0, irq_control_d};
        3'h2:    rdata_q <= {24'h0, 1'b1, edge_sel_q, 6'h3f};
        3'h3:    rdata_q <= {31'h0, pflag_d};
        3'h4:    rdata_q <= {31'h0, penable_q};
        3'h5:    rdata_q <= {26'h0, phase_q, any_pend,
                             o_dummy_cycle, o_sleeping, 1'b0};
        default: rdata_q <= 32'h0;
      endcase
    end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_VEC_NEEDS_GLOBAL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !irq_control_q[`MIL_IC_GLOBAL_EN] |=> !order_q.load_pc)
    else $error("vector taken with global enable clear");

  AST_VEC_CLEARS_GLOBAL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    vec_go |=> !irq_control_q[`MIL_IC_GLOBAL_EN] && order_q.load_pc
              && order_q.pc_value == `MIL_IRQ_VECTOR)
    else $error("vector did not clear enable or load pc");

  AST_RETURN_SETS_GLOBAL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_core.return_from_irq_instr && !vec_go |=> irq_control_q[`MIL_IC_GLOBAL_EN]
                                              && order_q.pop)
    else $error("return did not set global enable");

  AST_PIN_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (edge_sel_q ? pin_rise : pin_fall) |=> irq_control_q[`MIL_IC_EXT_FLAG])
    else $error("selected pin edge did not set flag");

  AST_TIMER_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_src.timer_wrap |=> irq_control_q[`MIL_IC_TMR_FLAG])
    else $error("timer wrap lost");

  AST_DUMMY_TWO: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    vec_go |=> o_dummy_cycle [*8] ##1 !o_dummy_cycle)
    else $error("dummy cycles not two instruction cycles");

  AST_LATENCY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_q == ST_RUN && any_pend && irq_control_q[`MIL_IC_GLOBAL_EN]
    && !i_core.sleep_enter |-> ##[0:3] vec_go)
    else $error("request not taken within one instruction cycle");

  AST_WAKE_ANY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_sleeping && wake_any |-> ##[1:4] order_q.wake ##0 !o_sleeping)
    else $error("enabled source failed to wake");

  AST_WAKE_NO_GLOBAL: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    order_q.wake && !$past(irq_control_q[`MIL_IC_GLOBAL_EN]) |-> state_q == ST_RUN)
    else $error("wake with enable clear went to vector");

endmodule
`default_nettype wire

// >>> mil_pkg.sv
// types shared by the interrupt logic
package mil_pkg;

  typedef enum logic [1:0] {ST_RUN, ST_DUMMY, ST_SLEEP} mil_state_t;

  // request sources as they arrive from the peripherals
  typedef struct packed {
    logic       ext_irq_pin;
    logic       timer_wrap;
    logic [3:0] port_hi;
    logic       conv_done;
  } mil_src_t;

  // instruction events from the core sequencer
  typedef struct packed {
    logic        return_from_irq_instr;
    logic        sleep_enter;
    logic        port_read;
    logic [12:0] ret_addr;
  } mil_core_t;

  // vectoring orders back to the core
  typedef struct packed {
    logic        load_pc;
    logic        push;
    logic        pop;
    logic        wake;
    logic [12:0] pc_value;
  } mil_order_t;

endpackage

// >>> testbench.sv
// self-checking bench for the interrupt logic
`timescale 1ns/1ns
`default_nettype none
`include "mil_consts.svh"
module testbench
  import mil_pkg::*;
;
  logic        i_sys_clk;
  logic        i_rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        resp;
  logic        ph1;
  mil_src_t    src;
  mil_core_t   core;
  mil_order_t  order;
  logic        dummy;
  logic        sleeping;
  logic        do_ret;
  logic        do_slp;
  logic [3:0]  depth;
  logic [31:0] rd;
  logic        hit;
  int          mismatches;
  int          n_tests;
  int          cnt;

  mil_irq_logic dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(resp), .i_src(src), .i_core(core),
    .o_order(order), .o_dummy_cycle(dummy), .o_sleeping(sleeping), .o_phase_one(ph1));
  mil_core_model core_model (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_order(order),
    .i_do_return(do_ret), .i_do_sleep(do_slp), .o_core(core), .o_depth(depth));

  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wait_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge i_sys_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  // ctl: read back the control register and compare
  task automatic ctl(input logic [7:0] exp);
    bus(1'b0, `MIL_OFF_IRQ_CONTROL, 32'h0);
    check("irq_control", rd, {24'h0, exp});
  endtask

  // which 0 waits for load_pc, 1 for wake
  task automatic wait_for(input logic which, input int lim);
    int k;
    k = 0;
    hit = 1'b0;
    while (!hit && k < lim)
    begin
      @(posedge i_sys_clk);
      k++;
      hit = ((which ? order.wake : order.load_pc) === 1'b1);
    end
  endtask

  task automatic pulse_ret;
    @(posedge i_sys_clk);
    do_ret <= 1'b1;
    @(posedge i_sys_clk);
    do_ret <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    i_rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = '0;
    do_ret = 1'b0;
    do_slp = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    ctl(8'h00);
    cnt = 0;
    repeat (8)
    begin
      @(posedge i_sys_clk);
      if (ph1 === 1'b1)
        cnt++;
    end
    check("phase_one_pulses", cnt, 32'h2);
    bus(1'b0, `MIL_OFF_OPTION, 32'h0);
    check("edge_select", {31'h0, rd[`MIL_OPT_EDGE_SEL]}, 32'h1);
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    check("hresp_okay", {31'h0, resp}, 32'h0);
    // pin flag rises without global enable and raises no vector
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h10);
    src.ext_irq_pin <= 1'b1;
    wait_for(1'b0, 16);
    check("masked_vector", {31'h0, hit}, 32'h0);
    ctl(8'h12);
    bus(1'b1, `MIL_OFF_OPTION, 32'h0);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h10);
    src.ext_irq_pin <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    ctl(8'h12);
    // global enable with a pending flag vectors at once
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h92);
    wait_for(1'b0, 16);
    check("vector", {31'h0, hit}, 32'h1);
    check("pc_value", {19'h0, order.pc_value}, {19'h0, `MIL_IRQ_VECTOR});
    cnt = 0;
    repeat (10)
    begin
      if (dummy === 1'b1)
        cnt++;
      @(posedge i_sys_clk);
    end
    check("dummy_clocks", cnt, 32'h8);
    check("stack_push", {28'h0, depth}, 32'h1);
    ctl(8'h12);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h10);
    pulse_ret();
    ctl(8'h90);
    check("stack_pop", {28'h0, depth}, 32'h0);
    // rising edge ignored with falling selected; falling edge vectors in time
    src.ext_irq_pin <= 1'b1;
    wait_for(1'b0, 12);
    check("wrong_edge", {31'h0, hit}, 32'h0);
    src.ext_irq_pin <= 1'b0;
    wait_for(1'b0, 16);
    check("latency", {31'h0, hit}, 32'h1);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h00);
    pulse_ret();
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h00);
    ctl(8'h00);
    // timer wrap: flag without enable, vector once enabled
    @(posedge i_sys_clk);
    src.timer_wrap <= 1'b1;
    @(posedge i_sys_clk);
    src.timer_wrap <= 1'b0;
    ctl(8'h04);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'ha4);
    wait_for(1'b0, 16);
    check("timer_vector", {31'h0, hit}, 32'h1);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h00);
    src.port_hi <= 4'h8;
    repeat (3) @(posedge i_sys_clk);
    ctl(8'h01);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h89);
    wait_for(1'b0, 16);
    check("port_vector", {31'h0, hit}, 32'h1);
    // converter request needs its enable and the peripheral master enable
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h00);
    @(posedge i_sys_clk);
    src.conv_done <= 1'b1;
    @(posedge i_sys_clk);
    src.conv_done <= 1'b0;
    bus(1'b0, `MIL_OFF_PFLAGS_ONE, 32'h0);
    check("pflags", rd, 32'h1);
    bus(1'b1, `MIL_OFF_PENABLE_ONE, 32'h1);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h80);
    wait_for(1'b0, 16);
    check("periph_gated", {31'h0, hit}, 32'h0);
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'hc0);
    wait_for(1'b0, 16);
    check("periph_vector", {31'h0, hit}, 32'h1);
    // sleep with pin enabled and global clear: wake without vector
    bus(1'b1, `MIL_OFF_PFLAGS_ONE, 32'h0);
    bus(1'b1, `MIL_OFF_PENABLE_ONE, 32'h0);
    src.ext_irq_pin <= 1'b1;
    bus(1'b1, `MIL_OFF_IRQ_CONTROL, 32'h10);
    do_slp <= 1'b1;
    @(posedge i_sys_clk);
    do_slp <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    check("sleeping", {31'h0, sleeping}, 32'h1);
    bus(1'b0, `MIL_OFF_STATUS, 32'h0);
    check("status_sleeping", {31'h0, rd[1]}, 32'h1);
    src.ext_irq_pin <= 1'b0;
    wait_for(1'b1, 16);
    check("wake", {31'h0, hit}, 32'h1);
    wait_for(1'b0, 12);
    check("no_vector", {31'h0, hit}, 32'h0);
    check("awake", {31'h0, sleeping}, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
